// ### verilog/uawb_defines.vh
// Register offsets, bit positions, reset values and counts for the serial port.
`ifndef UAWB_DEFINES_VH
`define UAWB_DEFINES_VH

`define UAWB_OFF_RXSC     4'h0
`define UAWB_OFF_RXDATA   4'h1
`define UAWB_OFF_TXSC     4'h2
`define UAWB_OFF_TXDATA   4'h3
`define UAWB_OFF_BAUDCTL  4'h4
`define UAWB_OFF_DIVHI    4'h5
`define UAWB_OFF_DIVLO    4'h6
`define UAWB_OFF_INTCTL   4'h7

`define UAWB_RX_PORTEN    7
`define UAWB_RX_NINTH     6
`define UAWB_RX_CONT      4
`define UAWB_RX_ADDR      3
`define UAWB_RX_FERR      2
`define UAWB_RX_OERR      1
`define UAWB_RX_BIT9      0

`define UAWB_TX_NINTH     6
`define UAWB_TX_EN        5
`define UAWB_TX_SYNC      4
`define UAWB_TX_BREAK     3
`define UAWB_TX_EMPTY     1
`define UAWB_TX_BIT9      0

`define UAWB_BC_IDLE      6
`define UAWB_BC_WAKE      1

`define UAWB_IC_RXIE      0
`define UAWB_IC_GIE       1
`define UAWB_IC_SLEEP     2
`define UAWB_IC_RXF       4
`define UAWB_IC_TXF       5

`define UAWB_RST_BYTE     8'h00
`define UAWB_RST_TXSC     8'h02
`define UAWB_OVS_LAST     4'hf
`define UAWB_OVS_MID      4'h7
`define UAWB_BRK_BITS     4'hc
`define UAWB_STOP8        4'h9
`define UAWB_STOP9        4'ha
`define UAWB_RESP_OKAY    2'b00
`define UAWB_RESP_SLVERR  2'b10

`endif

// ### verilog/uawb_sync2.v
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ns
module uawb_sync2 #(
  parameter RESET_VAL = 1'b1
) (
  input  wire clk_i,   // system clock
  input  wire rstn_i,  // asynchronous reset, active low
  input  wire d_i,     // asynchronous level
  output reg  q_o      // synchronised level
);
  reg meta;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // uawb_sync2

// ### verilog/uawb_top.v
// Serial port with address detect, wake on edge and break transmit.
// How it works
// - Ninth-bit enable makes receiver take nine-bit words.
// - Completed reception sets flag unless address detect drops the word; interrupt needs both enables.
// - Sleep stops the port's clocks and reception.
// - Wake enable holds receiver idle, watching the line.
// - Falling receive line edge is the wake event.
// - Wake event raises the receive flag, even asleep.
// - Reading receive data clears the wake flag.
// - Hardware clears wake enable on next rising edge.
// - Break is start, twelve zeros and stop.
// - Break request with transmit enable sends next buffered byte as break.
// - Break request clears itself after break's stop bit.
// - Shift-register-empty shows break activity like characters.
// - Wake mode flags a break's falling edge, then next byte.
// - Asynchronous frames: start, 8 or 9 bits, stop, LSB first.
`timescale 1ns/1ns
`include "uawb_defines.vh"
module uawb_top (
  input  wire        clk_i,          // system clock, 100 MHz
  input  wire        rstn_i,         // asynchronous reset, active low
  input  wire [31:0] s_axi_awaddr,   // write address
  input  wire        s_axi_awvalid,  // write address valid
  output reg         s_axi_awready,  // write address ready
  input  wire [31:0] s_axi_wdata,    // write data
  input  wire [3:0]  s_axi_wstrb,    // write byte strobes
  input  wire        s_axi_wvalid,   // write data valid
  output reg         s_axi_wready,   // write data ready
  output reg  [1:0]  s_axi_bresp,    // write response
  output reg         s_axi_bvalid,   // write response valid
  input  wire        s_axi_bready,   // write response ready
  input  wire [31:0] s_axi_araddr,   // read address
  input  wire        s_axi_arvalid,  // read address valid
  output reg         s_axi_arready,  // read address ready
  output reg  [31:0] s_axi_rdata,    // read data
  output reg  [1:0]  s_axi_rresp,    // read response
  output reg         s_axi_rvalid,   // read data valid
  input  wire        s_axi_rready,   // read data ready
  input  wire        receive_line_i, // serial receive pin
  output reg         transmit_line_o,// serial transmit pin
  output reg         irq_o           // receive interrupt request
);
  // Registers.
  reg  [7:0]  rxsc;
  reg  [7:0]  rx_data;
  reg  [7:0]  txsc;
  reg  [7:0]  tx_buf;
  reg         tx_buf_bit9;
  reg         tx_buf_full;
  reg         wake_en;
  reg  [7:0]  div_hi;
  reg  [7:0]  div_lo;
  reg  [2:0]  intctl;
  reg         rx_flag;
  // Bus state.
  reg         aw_held;
  reg         w_held;
  reg  [3:0]  aw_idx;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  // Line and baud state.
  wire        rx_s;
  reg         rx_prev;
  reg  [15:0] baud_cnt;
  wire        tick;
  reg  [3:0]  rx_ovs;
  reg  [3:0]  rx_bitn;
  reg  [8:0]  rx_shift;
  reg         rx_busy;
  reg         wake_seen;
  reg  [3:0]  tx_ovs;
  reg  [3:0]  tx_bitn;
  reg  [9:0]  tx_shift;
  reg         tx_busy;
  reg         tx_is_break;

  wire port_en = rxsc[`UAWB_RX_PORTEN] & ~txsc[`UAWB_TX_SYNC];
  // Sleep gates every baud-rate event, the same effect as stopped clocks.
  wire asleep  = intctl[`UAWB_IC_SLEEP];
  wire run     = port_en & ~asleep;
  wire [15:0] divisor = {div_hi, div_lo};
  assign tick  = run & (baud_cnt == divisor);
  wire nine    = rxsc[`UAWB_RX_NINTH];

  uawb_sync2 #(.RESET_VAL(1'b1)) u_rx_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (receive_line_i),
    .q_o    (rx_s)
  );

  wire fall = rx_prev & ~rx_s;
  wire rise = ~rx_prev & rx_s;

  // Bus decode: a write fires once address and data are both held.
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ok   = (aw_idx <= `UAWB_OFF_INTCTL) & w_strb[0];
  wire [7:0] wb = w_data[7:0];
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire [3:0] ar_idx = s_axi_araddr[5:2];
  wire rd_map  = (s_axi_araddr[31:6] == 26'h0) &
                 (ar_idx <= `UAWB_OFF_INTCTL);
  wire rd_rxdata = rd_fire & rd_map & (ar_idx == `UAWB_OFF_RXDATA);
  wire wr_tx   = wr_fire & wr_ok & (aw_idx == `UAWB_OFF_TXDATA);

  // Receive completion and address filtering.
  wire [3:0] rx_stop = nine ? `UAWB_STOP9 : `UAWB_STOP8;
  // Completion is taken at mid stop bit, so that the stop level is judged.
  wire rx_done  = rx_busy & tick & (rx_ovs == `UAWB_OVS_MID) &
                  (rx_bitn == rx_stop) & ~wake_en;
  wire stop_ok  = rx_s;
  wire word_b9  = nine ? rx_shift[8] : 1'b0;
  wire keep     = ~(rxsc[`UAWB_RX_ADDR] & nine) | word_b9;
  wire rx_load  = rx_done & keep & rxsc[`UAWB_RX_CONT];
  wire wake_evt = wake_en & ~wake_seen & fall;
  wire wake_end = wake_en & wake_seen & rise;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_prev  <= 1'b1;
      baud_cnt <= 16'h0000;
    end else begin
      rx_prev  <= rx_s;
      baud_cnt <= (tick | ~run) ? 16'h0000 : baud_cnt + 16'h0001;
    end
  end

  // Receiver: 16x oversampled, mid-bit sampling, LSB first.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_busy  <= 1'b0;
      rx_ovs   <= 4'h0;
      rx_bitn  <= 4'h0;
      rx_shift <= 9'h000;
    end else if (wake_en | ~rxsc[`UAWB_RX_CONT] | ~run) begin
      rx_busy  <= 1'b0;
      rx_ovs   <= 4'h0;
      rx_bitn  <= 4'h0;
    end else if (!rx_busy) begin
      if (fall) begin
        rx_busy <= 1'b1;
        rx_ovs  <= 4'h0;
        rx_bitn <= 4'h0;
      end
    end else if (tick) begin
      rx_ovs <= rx_ovs + 4'h1;
      if (rx_ovs == `UAWB_OVS_MID) begin
        if (rx_bitn == 4'h0 && rx_s) begin
          rx_busy <= 1'b0;
        end else if (rx_bitn == rx_stop) begin
          rx_busy <= 1'b0;
        end else if (rx_bitn != 4'h0) begin
          // Shift in from the top so bit 0 lands in position 0.
          rx_shift <= nine ? {rx_s, rx_shift[8:1]}
                           : {1'b0, rx_s, rx_shift[7:1]};
        end
      end
      if (rx_ovs == `UAWB_OVS_LAST) begin
        rx_bitn <= rx_bitn + 4'h1;
      end
    end
  end

  // Receive flag: hardware set wins over the clearing read.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_flag   <= 1'b0;
      rx_data   <= `UAWB_RST_BYTE;
      wake_seen <= 1'b0;
      wake_en   <= 1'b0;
    end else begin
      if (rx_load | wake_evt) begin
        rx_flag <= 1'b1;
      end else if (rd_rxdata) begin
        rx_flag <= 1'b0;
      end
      if (rx_load) begin
        rx_data <= rx_shift[7:0];
      end
      if (wake_evt) begin
        wake_seen <= 1'b1;
      end else if (~wake_en) begin
        wake_seen <= 1'b0;
      end
      if (wake_end) begin
        wake_en <= 1'b0;
      end else if (wr_fire & wr_ok & (aw_idx == `UAWB_OFF_BAUDCTL)) begin
        wake_en <= wb[`UAWB_BC_WAKE];
      end
    end
  end

  // Receive status and control; error bits clear while continuous receive is off.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rxsc <= `UAWB_RST_BYTE;
    end else begin
      if (wr_fire & wr_ok & (aw_idx == `UAWB_OFF_RXSC)) begin
        rxsc[7:3] <= wb[7:3];
      end
      if (rx_load) begin
        rxsc[`UAWB_RX_BIT9] <= word_b9;
        if (!stop_ok) begin
          rxsc[`UAWB_RX_FERR] <= 1'b1;
        end
        if (rx_flag & ~rd_rxdata) begin
          rxsc[`UAWB_RX_OERR] <= 1'b1;
        end
      end else if (~rxsc[`UAWB_RX_CONT]) begin
        rxsc[`UAWB_RX_FERR] <= 1'b0;
        rxsc[`UAWB_RX_OERR] <= 1'b0;
      end
    end
  end

  // Transmitter: buffer plus shift register; break sends twelve zeros.
  wire tx_en   = txsc[`UAWB_TX_EN];
  wire [3:0] tx_last = tx_is_break ? (`UAWB_BRK_BITS + 4'h1) :
                       (txsc[`UAWB_TX_NINTH] ? `UAWB_STOP9 : `UAWB_STOP8);
  wire tx_bit_end = tx_busy & tick & (tx_ovs == `UAWB_OVS_LAST);
  wire tx_finish  = tx_bit_end & (tx_bitn == tx_last);
  wire tx_start   = tx_buf_full & tx_en & run & (~tx_busy | tx_finish);
  // A break that ends as the queued byte starts must not send it as a break.
  wire brk_done   = tx_finish & tx_is_break;
  wire brk_next   = txsc[`UAWB_TX_BREAK] & ~brk_done;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_busy         <= 1'b0;
      tx_is_break     <= 1'b0;
      tx_ovs          <= 4'h0;
      tx_bitn         <= 4'h0;
      tx_shift        <= 10'h3ff;
      tx_buf_full     <= 1'b0;
      tx_buf          <= `UAWB_RST_BYTE;
      tx_buf_bit9     <= 1'b0;
      transmit_line_o <= 1'b1;
      txsc            <= `UAWB_RST_TXSC;
    end else begin
      if (wr_fire & wr_ok & (aw_idx == `UAWB_OFF_TXSC)) begin
        txsc <= {wb[7:2], txsc[`UAWB_TX_EMPTY], wb[0]};
      end
      if (wr_tx) begin
        tx_buf      <= wb;
        tx_buf_bit9 <= txsc[`UAWB_TX_BIT9];
        tx_buf_full <= 1'b1;
      end else if (tx_start) begin
        tx_buf_full <= 1'b0;
      end
      if (tx_start) begin
        tx_busy     <= 1'b1;
        tx_ovs      <= 4'h0;
        tx_bitn     <= 4'h0;
        tx_is_break <= brk_next;
        // Break ignores the written value and shifts zeros.
        tx_shift    <= brk_next ? 10'h000 :
                       {tx_buf_bit9, tx_buf, 1'b0};
        transmit_line_o <= 1'b0;
      end else if (tx_finish) begin
        tx_busy         <= 1'b0;
        transmit_line_o <= 1'b1;
      end else if (tx_bit_end) begin
        tx_ovs  <= 4'h0;
        tx_bitn <= tx_bitn + 4'h1;
        tx_shift <= {1'b1, tx_shift[9:1]};
        // The last bit slot is the stop bit.
        transmit_line_o <= ((tx_bitn + 4'h1) == tx_last) ? 1'b1 :
                           (tx_is_break ? 1'b0 : tx_shift[1]);
      end else if (tx_busy & tick) begin
        tx_ovs <= tx_ovs + 4'h1;
      end
      if (brk_done) begin
        txsc[`UAWB_TX_BREAK] <= 1'b0;
      end
      txsc[`UAWB_TX_EMPTY] <= ~(tx_busy | tx_start) |
                              (tx_finish & ~tx_start);
    end
  end

  // Remaining software registers and the interrupt line.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_hi <= `UAWB_RST_BYTE;
      div_lo <= `UAWB_RST_BYTE;
      intctl <= 3'h0;
      irq_o  <= 1'b0;
    end else begin
      if (wr_fire & wr_ok & (aw_idx == `UAWB_OFF_DIVHI)) begin
        div_hi <= wb;
      end
      if (wr_fire & wr_ok & (aw_idx == `UAWB_OFF_DIVLO)) begin
        div_lo <= wb;
      end
      if (wr_fire & wr_ok & (aw_idx == `UAWB_OFF_INTCTL)) begin
        intctl <= wb[2:0];
      end
      irq_o <= rx_flag & intctl[`UAWB_IC_RXIE] & intctl[`UAWB_IC_GIE];
    end
  end

  // AXI4-Lite write channel: address and data accepted in either order.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 4'h0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UAWB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_idx        <= (s_axi_awaddr[31:6] == 26'h0) ?
                         s_axi_awaddr[5:2] : 4'hf;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx <= `UAWB_OFF_INTCTL) ?
                        `UAWB_RESP_OKAY : `UAWB_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel.
  reg [7:0] rd_byte;
  always @* begin
    case (ar_idx)
      `UAWB_OFF_RXSC:    rd_byte = rxsc;
      `UAWB_OFF_RXDATA:  rd_byte = rx_data;
      `UAWB_OFF_TXSC:    rd_byte = txsc;
      `UAWB_OFF_TXDATA:  rd_byte = tx_buf;
      `UAWB_OFF_BAUDCTL: rd_byte = {1'b0, ~rx_busy, 4'h0, wake_en, 1'b0};
      `UAWB_OFF_DIVHI:   rd_byte = div_hi;
      `UAWB_OFF_DIVLO:   rd_byte = div_lo;
      `UAWB_OFF_INTCTL:  rd_byte = {2'b00, ~tx_buf_full, rx_flag, 1'b0,
                                    intctl};
      default:           rd_byte = `UAWB_RST_BYTE;
    endcase
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `UAWB_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_map ? {24'h000000, rd_byte} : 32'h0000_0000;
      s_axi_rresp   <= rd_map ? `UAWB_RESP_OKAY : `UAWB_RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // uawb_top

// ### test/uawb_top_properties.sv
// Port checks: bus answers, transmit bit timing, interrupt gating and wake.
`timescale 1ns/1ns
module uawb_top_properties (
  input wire        clk_i, rstn_i,                   // clock, reset
  input wire [31:0] s_axi_awaddr, s_axi_wdata,       // write payload
  input wire [31:0] s_axi_araddr, s_axi_rdata,       // read payload
  input wire [3:0]  s_axi_wstrb,                     // byte strobes
  input wire [1:0]  s_axi_bresp, s_axi_rresp,        // responses
  input wire        s_axi_awvalid, s_axi_awready,    // write address
  input wire        s_axi_wvalid, s_axi_wready,      // write data
  input wire        s_axi_bvalid, s_axi_bready,      // write response
  input wire        s_axi_arvalid, s_axi_arready,    // read address
  input wire        s_axi_rvalid, s_axi_rready,      // read data
  input wire        receive_line_i, transmit_line_o, // serial lines
  input wire        irq_o                            // interrupt
);
  localparam int BRK_CLKS = 208;
  reg [8:0] low_run;
  reg       en;
  reg       armed;
  wire      wr_ok = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                    s_axi_wready && s_axi_wstrb[0];

  // Enables and wake arming are shadowed from bus writes, since the
  // checker cannot see the registers themselves.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_run <= 9'h000;
      en <= 1'b0;
      armed <= 1'b0;
    end else begin
      low_run <= transmit_line_o ? 9'h000 : low_run + 9'h001;
      if (wr_ok && s_axi_awaddr == 32'h1c) begin
        en <= s_axi_wdata[1:0] == 2'b11;
      end
      if (wr_ok && s_axi_awaddr == 32'h10) begin
        armed <= s_axi_wdata[1];
      end else if ($rose(receive_line_i)) begin
        armed <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wake_fall;
    armed && en && $fell(receive_line_i);
  endsequence

  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (
    rd_take |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
  rd_slverr_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 32'h40
    |=> s_axi_rresp == 2'b10) else $error("unmapped read not refused");
  rd_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  tx_idle_a: assert property (
    !$past(rstn_i) |-> transmit_line_o && !irq_o) else $error("not idle");
  tx_bit_a: assert property (
    $rose(transmit_line_o) |-> low_run[3:0] == 4'h0)
    else $error("transmit bit not whole");
  tx_break_a: assert property (
    low_run <= BRK_CLKS) else $error("transmit low too long");
  irq_gate_a: assert property (
    irq_o |-> en || $past(en)) else $error("interrupt without enables");
  wake_flag_a: assert property (
    wake_fall |-> ##[1:8] irq_o) else $error("wake edge not flagged");
  rx_clear_a: assert property (
    rd_take ##0 (s_axi_araddr == 32'h04 && irq_o && !armed)
    |-> ##[1:3] !irq_o) else $error("data read left flag set");
endmodule // uawb_top_properties

bind uawb_top uawb_top_properties u_uawb_top_properties (.*);

// ### test/uawb_node.sv
// Remote serial node: drives the receive line and decodes the transmit line.
`timescale 1ns/1ns
module uawb_node #(
  parameter int BIT_CLKS = 16
) (
  input  wire        clk_i,     // system clock
  input  wire        line_i,    // frames from the block
  output reg         line_o,    // frames to the block
  output reg         got_o,     // one-cycle pulse per decoded frame
  output reg  [12:0] got_val_o  // low slots after start, then data byte
);
  integer   i;
  integer   z;
  reg [7:0] d;
  reg       hi;

  // The stop level is an argument so that a framing fault can be made.
  task automatic send(input logic [11:0] data, input int n, input logic s);
    int k;
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (k = 0; k < n; k++) begin
      line_o <= data[k];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= s;
    repeat (BIT_CLKS) @(posedge clk_i);
    line_o <= 1'b1;
  endtask

  // Holds the line low for a number of clocks, for a break at any rate.
  task automatic hold_low(input int c);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (c) @(posedge clk_i);
    line_o <= 1'b1;
  endtask

  // A low stop slot means a break, so low slots are counted to a high one.
  initial begin
    line_o = 1'b1;
    got_o = 1'b0;
    got_val_o = 13'h0000;
    forever begin
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      z = 0;
      hi = 1'b0;
      d = 8'h00;
      for (i = 0; i < 9 || (!hi && i < 16); i++) begin
        repeat (BIT_CLKS) @(posedge clk_i);
        if (i < 8) d[i] = line_i;
        if (line_i) hi = 1'b1;
        else if (!hi) z++;
      end
      got_val_o <= {z[4:0], d};
      got_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
    end
  end
endmodule // uawb_node

// ### test/uart_addr_wake_break_bench.sv
// Self-checking bench: bus tasks, queued expectations, serial node partner.
`timescale 1ns/1ns
module uart_addr_wake_break_bench;
  logic        clk_i, rstn_i, receive_line_i, transmit_line_o, irq_o;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, got;
  logic [12:0] got_val;
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  logic [1:0]  bq[$];
  logic [12:0] tq[$];
  logic [31:0] rng;
  int          fail_count, n_checks, cyc;

  uawb_top u_uawb_top (.*);
  uawb_node u_uawb_node (.clk_i(clk_i), .line_i(transmit_line_o),
    .line_o(receive_line_i), .got_o(got), .got_val_o(got_val));

  always #5 clk_i = ~clk_i;

  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic wr(input logic [31:0] a, d, input logic [1:0] r = 2'b00);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk_i); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk_i); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clk_i); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask

  // A lag keeps rready low for a while, so a held answer is exercised.
  task automatic rd(input logic [31:0] a, e, m, input logic [1:0] r = 2'b00,
                    input int lag = 0);
    rq.push_back({r, e & m});
    mq.push_back(m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (lag) @(posedge clk_i);
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask

  // Two flops of synchroniser plus the flag fit well inside six cycles.
  task automatic rx(input logic [11:0] d, input int n, input logic s);
    u_uawb_node.send(d, n, s);
    repeat (6) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (s_axi_rvalid && s_axi_rready)
      cmp({s_axi_rresp, s_axi_rdata & mq.pop_front()}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      cmp({s_axi_bresp, 32'h0}, {bq.pop_front(), 32'h0});
    if (got)
      cmp({21'h0, got_val}, {21'h0, tq.pop_front()});
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    rng = 32'h408b;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(32'h00, 32'h00, 32'hff);
    wr(32'h08, 32'h00);
    rd(32'h08, 32'h02, 32'hff);
    rd(32'h40, 32'h00, 32'h00, 2'b10);
    wr(32'h40, 32'hff, 2'b10);
    wr(32'h18, 32'h00);
    wr(32'h14, 32'h00);
    wr(32'h1c, 32'h03);
    wr(32'h00, 32'hd8);
    rng = xs(rng);
    rx({4'h0, rng[7:0]}, 9, 1'b1);
    rd(32'h1c, 32'h00, 32'h10);
    rx({4'h1, rng[15:8]}, 9, 1'b1);
    rd(32'h1c, 32'h10, 32'h10);
    rd(32'h00, 32'h01, 32'h07);
    rd(32'h04, rng[15:8], 32'hff);
    rd(32'h1c, 32'h00, 32'h10);
    wr(32'h00, 32'hd0);
    rx({4'h0, rng[23:16]}, 9, 1'b1);
    rd(32'h00, 32'h00, 32'h01);
    rd(32'h04, rng[23:16], 32'hff);
    rx({4'h1, rng[31:24]}, 9, 1'b0);
    rd(32'h00, 32'h04, 32'h04);
    rd(32'h04, 32'h00, 32'h00);
    wr(32'h00, 32'hc0);
    rd(32'h00, 32'h00, 32'h04);
    wr(32'h00, 32'h90);
    wr(32'h08, 32'h28);
    rng = xs(rng);
    tq.push_back(13'h0c00);
    tq.push_back(13'h0055);
    wr(32'h0c, rng);
    wr(32'h0c, 32'h55);
    rd(32'h08, 32'h08, 32'h0a);
    while (tq.size() != 0) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    rd(32'h08, 32'h22, 32'h2a);
    rd(32'h1c, 32'h20, 32'h20);
    wr(32'h1c, 32'h07);
    rx({4'h0, rng[15:8]}, 8, 1'b1);
    rd(32'h1c, 32'h00, 32'h10);
    rd(32'h10, 32'h40, 32'h40);
    wr(32'h10, 32'h02);
    fork
      u_uawb_node.send(12'h000, 12, 1'b1);
      begin
        repeat (40) @(posedge clk_i);
        rd(32'h1c, 32'h10, 32'h10);
        rd(32'h10, 32'h02, 32'h02);
      end
    join
    repeat (6) @(posedge clk_i);
    rd(32'h10, 32'h00, 32'h02);
    rd(32'h04, 32'h00, 32'h00);
    rd(32'h1c, 32'h00, 32'h10);
    wr(32'h1c, 32'h03);
    rx({4'h0, rng[23:16]}, 8, 1'b1);
    rd(32'h1c, 32'h10, 32'h10);
    rd(32'h04, rng[23:16], 32'hff);
    // Thirteen low bits of 144 clocks seen by a receiver bit of 208 clocks.
    wr(32'h18, 32'h0c);
    u_uawb_node.hold_low(13 * 9 * 16);
    repeat (150) @(posedge clk_i);
    rd(32'h1c, 32'h10, 32'h10);
    rd(32'h00, 32'h00, 32'h04);
    rd(32'h04, 32'h00, 32'hff, 2'b00, 2);
    final_report();
  end
endmodule // uart_addr_wake_break_bench
